//--- rtl/timer_pkg.sv
package timer_pkg;

	// Byte addresses on the peripheral bus; even is upper byte, odd is lower byte
	localparam logic [3:0] ADDR_COUNT_HI     = 4'h0;
	localparam logic [3:0] ADDR_COUNT_LO     = 4'h1;
	localparam logic [3:0] ADDR_COMPARE_HI   = 4'h2;
	localparam logic [3:0] ADDR_COMPARE_LO   = 4'h3;
	localparam logic [3:0] ADDR_CAP_A_HI     = 4'h4;
	localparam logic [3:0] ADDR_CAP_A_LO     = 4'h5;
	localparam logic [3:0] ADDR_CAP_B_HI     = 4'h6;
	localparam logic [3:0] ADDR_CAP_B_LO     = 4'h7;
	localparam logic [3:0] ADDR_CAP_C_HI     = 4'h8;
	localparam logic [3:0] ADDR_CAP_C_LO     = 4'h9;
	localparam logic [3:0] ADDR_CAP_D_HI     = 4'hA;
	localparam logic [3:0] ADDR_CAP_D_LO     = 4'hB;
	localparam logic [3:0] ADDR_CAPTURE_CTRL = 4'hC;
	localparam logic [3:0] ADDR_COMPARE_CTRL = 4'hD;

	// Reset values and fixed bits
	localparam logic [7:0]  CAPTURE_CTRL_RESET  = 8'h00;
	localparam logic [7:0]  COMPARE_CTRL_RESET  = 8'hE0;
	localparam logic [7:0]  COMPARE_CTRL_FIXED  = 8'hE0;
	localparam logic [7:0]  UNMAPPED_READ       = 8'h00;
	localparam logic [15:0] WORD_RESET          = 16'h0000;
	localparam logic [15:0] COUNT_TOP           = 16'hFFFF;

	// Field positions in capture_edge_clock_control
	localparam int EDGE_A_BIT  = 7;
	localparam int EDGE_B_BIT  = 6;
	localparam int EDGE_C_BIT  = 5;
	localparam int EDGE_D_BIT  = 4;
	localparam int BUF_A_BIT   = 3;
	localparam int BUF_B_BIT   = 2;
	localparam int SRC_HI_BIT  = 1;
	localparam int SRC_LO_BIT  = 0;

	// Field positions in compare_output_control
	localparam int SEL_BIT     = 4;
	localparam int EN_A_BIT    = 3;
	localparam int EN_B_BIT    = 2;
	localparam int LVL_A_BIT   = 1;
	localparam int LVL_B_BIT   = 0;

	// Count source codes and prescaler masks (count when low bits all ones)
	localparam logic [1:0] SRC_DIV2     = 2'h0;
	localparam logic [1:0] SRC_DIV8     = 2'h1;
	localparam logic [1:0] SRC_DIV32    = 2'h2;
	localparam logic [1:0] SRC_EXTERNAL = 2'h3;
	localparam logic [4:0] DIV2_MASK    = 5'h01;
	localparam logic [4:0] DIV8_MASK    = 5'h07;
	localparam logic [4:0] DIV32_MASK   = 5'h1F;

	// Host byte access
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	// Which 16-bit word an address reaches
	typedef enum logic [2:0] {
		WORD_NONE,
		WORD_COUNT,
		WORD_COMPARE,
		WORD_CAP_A,
		WORD_CAP_B,
		WORD_CAP_C,
		WORD_CAP_D
	} word_sel_t;

	function automatic word_sel_t word_of(input logic [3:0] addr);
		if (addr[3:1] == ADDR_COUNT_HI[3:1])
			return WORD_COUNT;
		else if (addr[3:1] == ADDR_COMPARE_HI[3:1])
			return WORD_COMPARE;
		else if (addr[3:1] == ADDR_CAP_A_HI[3:1])
			return WORD_CAP_A;
		else if (addr[3:1] == ADDR_CAP_B_HI[3:1])
			return WORD_CAP_B;
		else if (addr[3:1] == ADDR_CAP_C_HI[3:1])
			return WORD_CAP_C;
		else if (addr[3:1] == ADDR_CAP_D_HI[3:1])
			return WORD_CAP_D;
		else
			return WORD_NONE;
	endfunction : word_of

endpackage : timer_pkg

//--- rtl/count_source.sv
`timescale 1ns/1ps
// Makes the one-cycle count enable for the counter from the selected source
module count_source
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [1:0] i_source,
	input  wire logic       i_ext_clk,
	output logic            o_count_en
);

	typedef struct packed {
		logic [4:0] prescale;
		logic       ext_prev;
		logic       primed;
	} src_state_t;

	src_state_t s;
	src_state_t next_s;
	logic [4:0] mask;

	// Prescaler runs freely; a switch of source may give one short first period
	always_comb
	begin
		next_s          = s;
		next_s.prescale = s.prescale + 5'h01;
		next_s.ext_prev = i_ext_clk;
		next_s.primed   = 1'b1;
		if (i_source == timer_pkg::SRC_DIV2)
			mask = timer_pkg::DIV2_MASK;
		else if (i_source == timer_pkg::SRC_DIV8)
			mask = timer_pkg::DIV8_MASK;
		else
			mask = timer_pkg::DIV32_MASK;
	end

	assign o_count_en = s.primed & ((i_source == timer_pkg::SRC_EXTERNAL)
		? (i_ext_clk & ~s.ext_prev)
		: ((s.prescale & mask) == mask));

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			s <= '0;
		else
			s <= next_s;
	end

endmodule : count_source

//--- rtl/capture_edge.sv
`timescale 1ns/1ps
// Per-input edge detector with selectable polarity, index 0..3 is A..D
module capture_edge
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_pin,
	input  wire logic [3:0] i_rising,
	output logic      [3:0] o_edge
);

	typedef struct packed {
		logic [3:0] prev;
		logic       primed;
	} edge_state_t;

	edge_state_t s;
	edge_state_t next_s;

	// No edge is reported until a real previous sample exists
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_edge
			assign o_edge[g] = s.primed & (i_rising[g] ? (i_pin[g] & ~s.prev[g])
				: (~i_pin[g] & s.prev[g]));
		end
	endgenerate

	always_comb
	begin
		next_s        = s;
		next_s.prev   = i_pin;
		next_s.primed = 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			s <= '0;
		else
			s <= next_s;
	end

endmodule : capture_edge

//--- rtl/free_timer.sv
`timescale 1ns/1ps
// Overview of operation
// - capture control clears on reset, low power
// - edge bit 0 falling, 1 rising
// - bit 3 makes C buffer A
// - bit 2 makes D buffer B
// - source field picks divide or external
// - compare control resets to E0
// - top three compare control bits read one
// - select bit steers shared compare address
// - enable A lets compare A drive pin
// - enable B lets compare B drive pin
// - match A drives level A
// - match B drives level B
// - one byte latch reaches all words
// - upper write latches, lower write commits
// - upper read latches lower for later
// - compare reads bypass the latch
// - pins read zero until first match
// - buffered capture shifts old value along
module free_timer
(
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	input  wire logic                i_low_power,
	input  wire timer_pkg::bus_req_t i_bus,
	output logic [7:0]               o_bus_rdata,
	input  wire logic [3:0]          i_capture_pin,
	input  wire logic                i_ext_clk,
	output logic [1:0]               o_compare_pin,
	output logic [1:0]               o_compare_pin_oe,
	output logic [3:0]               o_capture_event,
	output logic [1:0]               o_compare_match,
	output logic                     o_overflow
);

	typedef struct packed {
		logic [15:0]       count;
		logic [1:0][15:0]  ocr;
		logic [3:0][15:0]  icr;
		logic [7:0]        temp;
		logic [7:0]        cap_ctrl;
		logic [7:0]        cmp_ctrl;
		logic [1:0]        pin_level;
		logic [7:0]        rdata;
		logic [3:0]        cap_hold;
	} timer_state_t;

	localparam timer_state_t STATE_RESET = '{
		count:     timer_pkg::WORD_RESET,
		ocr:       '0,
		icr:       '0,
		temp:      8'h00,
		cap_ctrl:  timer_pkg::CAPTURE_CTRL_RESET,
		cmp_ctrl:  timer_pkg::COMPARE_CTRL_RESET,
		pin_level: 2'h0,
		rdata:     8'h00,
		cap_hold:  4'h0
	};

	timer_state_t s;
	timer_state_t next_s;

	logic                 clear;
	logic                 count_en;
	logic [3:0]           edge_seen;
	logic [3:0]           rising;
	logic [3:0]           blocked;
	logic [3:0]           fire;
	logic [1:0]           match;
	logic                 buf_a;
	logic                 buf_b;
	logic                 cmp_sel;
	logic                 upper;
	logic                 lower;
	timer_pkg::word_sel_t word;

	// Low-power modes reset the whole timer just as the chip reset does
	assign clear   = i_rst | i_low_power;
	assign buf_a   = s.cap_ctrl[timer_pkg::BUF_A_BIT];
	assign buf_b   = s.cap_ctrl[timer_pkg::BUF_B_BIT];
	assign cmp_sel = s.cmp_ctrl[timer_pkg::SEL_BIT];
	assign word    = timer_pkg::word_of(i_bus.addr);
	assign upper   = ~i_bus.addr[0];
	assign lower   = i_bus.addr[0];
	assign rising  = {s.cap_ctrl[timer_pkg::EDGE_D_BIT], s.cap_ctrl[timer_pkg::EDGE_C_BIT],
		s.cap_ctrl[timer_pkg::EDGE_B_BIT], s.cap_ctrl[timer_pkg::EDGE_A_BIT]};

	count_source u_count_source
	(
		.i_clk      (i_clk),
		.i_rst      (clear),
		.i_source   (s.cap_ctrl[timer_pkg::SRC_HI_BIT:timer_pkg::SRC_LO_BIT]),
		.i_ext_clk  (i_ext_clk),
		.o_count_en (count_en)
	);

	capture_edge u_capture_edge
	(
		.i_clk    (i_clk),
		.i_rst    (clear),
		.i_pin    (i_capture_pin),
		.i_rising (rising),
		.o_edge   (edge_seen)
	);

	// A capture landing during an upper-byte read of its word waits one clock,
	// so the lower byte parked in the latch still belongs to the word just read
	always_comb
	begin
		blocked    = 4'h0;
		blocked[0] = i_bus.rd & upper & ((word == timer_pkg::WORD_CAP_A)
			| (buf_a & (word == timer_pkg::WORD_CAP_C)));
		blocked[1] = i_bus.rd & upper & ((word == timer_pkg::WORD_CAP_B)
			| (buf_b & (word == timer_pkg::WORD_CAP_D)));
		blocked[2] = i_bus.rd & upper & ((word == timer_pkg::WORD_CAP_C)
			| (buf_a & (word == timer_pkg::WORD_CAP_A)));
		blocked[3] = i_bus.rd & upper & ((word == timer_pkg::WORD_CAP_D)
			| (buf_b & (word == timer_pkg::WORD_CAP_B)));
	end

	assign fire = (edge_seen | s.cap_hold) & ~blocked;

	// Match fires on the counter's last clock at the matching value
	assign match[0] = count_en & (s.count == s.ocr[0]);
	assign match[1] = count_en & (s.count == s.ocr[1]);

	// Next state of the timer core and its byte port
	always_comb
	begin
		next_s          = s;
		next_s.cap_hold = (edge_seen | s.cap_hold) & blocked;

		if (count_en)
			next_s.count = s.count + 16'h0001;

		if (fire[0])
		begin
			next_s.icr[0] = s.count;
			if (buf_a)
				next_s.icr[2] = s.icr[0];
		end
		if (fire[1])
		begin
			next_s.icr[1] = s.count;
			if (buf_b)
				next_s.icr[3] = s.icr[1];
		end
		// In buffered mode an edge on C or D only raises its event, no transfer
		if (fire[2] & ~buf_a)
			next_s.icr[2] = s.count;
		if (fire[3] & ~buf_b)
			next_s.icr[3] = s.count;

		if (match[0])
			next_s.pin_level[0] = s.cmp_ctrl[timer_pkg::LVL_A_BIT];
		if (match[1])
			next_s.pin_level[1] = s.cmp_ctrl[timer_pkg::LVL_B_BIT];

		if (i_bus.wr)
		begin
			if (i_bus.addr == timer_pkg::ADDR_CAPTURE_CTRL)
				next_s.cap_ctrl = i_bus.wdata;
			else if (i_bus.addr == timer_pkg::ADDR_COMPARE_CTRL)
				next_s.cmp_ctrl = i_bus.wdata | timer_pkg::COMPARE_CTRL_FIXED;
			else if ((word != timer_pkg::WORD_NONE) && upper)
				next_s.temp = i_bus.wdata;
			else if (word == timer_pkg::WORD_COUNT)
				// lower write commits; the host write beats a count
				next_s.count = {s.temp, i_bus.wdata};
			else if (word == timer_pkg::WORD_COMPARE)
				next_s.ocr[cmp_sel] = {s.temp, i_bus.wdata};
		end

		// Byte port reads; capture words accept no writes
		if (i_bus.rd)
		begin
			if (i_bus.addr == timer_pkg::ADDR_CAPTURE_CTRL)
				next_s.rdata = s.cap_ctrl;
			else if (i_bus.addr == timer_pkg::ADDR_COMPARE_CTRL)
				next_s.rdata = s.cmp_ctrl | timer_pkg::COMPARE_CTRL_FIXED;
			else if (word == timer_pkg::WORD_COMPARE)
				next_s.rdata = upper ? s.ocr[cmp_sel][15:8] : s.ocr[cmp_sel][7:0];
			else if ((word != timer_pkg::WORD_NONE) && upper)
			begin
				if (word == timer_pkg::WORD_COUNT)
				begin
					next_s.rdata = s.count[15:8];
					next_s.temp  = s.count[7:0];
				end
				else
				begin
					next_s.rdata = s.icr[word - timer_pkg::WORD_CAP_A][15:8];
					next_s.temp  = s.icr[word - timer_pkg::WORD_CAP_A][7:0];
				end
			end
			else if ((word != timer_pkg::WORD_NONE) && lower)
				next_s.rdata = s.temp;
			else
				next_s.rdata = timer_pkg::UNMAPPED_READ;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (clear)
			s <= STATE_RESET;
		else
			s <= next_s;
	end

	assign o_bus_rdata = s.rdata;
	assign o_compare_pin = s.pin_level;
	assign o_compare_pin_oe = {s.cmp_ctrl[timer_pkg::EN_B_BIT], s.cmp_ctrl[timer_pkg::EN_A_BIT]};
	assign o_capture_event  = fire;
	assign o_compare_match  = match;
	assign o_overflow       = count_en & (s.count == timer_pkg::COUNT_TOP);

endmodule : free_timer

//--- verification/timer_sva.sv
`timescale 1ns/1ps
// Port-level checks of the timer control and byte access block
module timer_sva
(
	input wire logic                i_clk,
	input wire logic                i_rst,
	input wire logic                i_low_power,
	input wire timer_pkg::bus_req_t i_bus,
	input wire logic [7:0]          o_bus_rdata,
	input wire logic [3:0]          i_capture_pin,
	input wire logic [1:0]          o_compare_pin,
	input wire logic [1:0]          o_compare_pin_oe,
	input wire logic [3:0]          o_capture_event,
	input wire logic [1:0]          o_compare_match
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// Write strobe on the compare control byte, and any clearing cycle
	logic ctrl_wr;
	logic clr;
	assign ctrl_wr = i_bus.wr && (i_bus.addr == timer_pkg::ADDR_COMPARE_CTRL);
	assign clr     = i_rst || i_low_power;

	pins_cleared_a: assert property ($past(clr) |-> o_compare_pin == 2'h0 && o_compare_pin_oe == 2'h0)
		else $error("compare pins not cleared");
	reserved_ones_a: assert property (i_bus.rd && !i_low_power && i_bus.addr == 4'hD |=> o_bus_rdata[7:5] == 3'h7)
		else $error("reserved bits not read as one");
	unmapped_zero_a: assert property (i_bus.rd && !i_low_power && i_bus.addr == 4'hE |=> o_bus_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_holds_a: assert property (!i_bus.rd && !i_low_power |=> $stable(o_bus_rdata))
		else $error("read data moved without a read");
	pin_a_hold_a: assert property (!$past(clr) && !$past(o_compare_match[0]) |-> $stable(o_compare_pin[0]))
		else $error("pin A moved without match");
	pin_b_hold_a: assert property (!$past(clr) && !$past(o_compare_match[1]) |-> $stable(o_compare_pin[1]))
		else $error("pin B moved without match");
	// Enables only follow a control write, taking effect one or two edges on
	enable_source_a: assert property ($changed(o_compare_pin_oe) && !$past(clr) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
		else $error("pin enable changed without write");
	match_pulse_a: assert property (o_compare_match[0] |=> !o_compare_match[0])
		else $error("match pulse too long");
	capture_cause_a: assert property (o_capture_event[0] |-> i_capture_pin[0] != $past(i_capture_pin[0], 2))
		else $error("capture event without pin edge");
endmodule : timer_sva

//--- verification/cpu_host.sv
`timescale 1ns/1ps
// Byte-wide host; drives on the falling edge, holds one rising edge
module cpu_host
(
	input  wire logic           i_clk,
	input  wire logic [7:0]     i_rdata,
	output timer_pkg::bus_req_t o_bus
);
	initial o_bus = '0;

	// Released lines show inverted values so stale data is never trusted
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_bus = '{1'b0, 1'b1, a, d};
		@(negedge i_clk);
		o_bus = '{1'b0, 1'b0, ~a, ~d};
	endtask : wr8

	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_bus = '{1'b1, 1'b0, a, 8'h00};
		@(negedge i_clk);
		o_bus = '{1'b0, 1'b0, ~a, 8'hFF};
		d = i_rdata;
	endtask : rd8

	task automatic wr16(input logic [3:0] a, input logic [15:0] w);
		wr8(a, w[15:8]);
		wr8(a + 4'h1, w[7:0]);
	endtask : wr16

	task automatic rd16(input logic [3:0] a, output logic [15:0] w);
		rd8(a, w[15:8]);
		rd8(a + 4'h1, w[7:0]);
	endtask : rd16
endmodule : cpu_host

//--- verification/free_timer_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the timer control and byte access block
module free_timer_bench;
	typedef struct packed {logic [3:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                lp = 1'b0;
	logic [3:0]          cap = 4'h0;
	logic                ext = 1'b0;
	timer_pkg::bus_req_t bus;
	logic [7:0]          rdata;
	logic [1:0]          pin;
	logic [1:0]          pin_oe;
	logic [7:0]          d8;
	logic [15:0]         got;
	int                  error_cnt = 0;
	int                  checks_done = 0;
	// Last row leaves the external source selected so the count stands still
	row_t rows [8] = '{'{4'hC, 8'h00, 8'h00}, '{4'hC, 8'h55, 8'h55}, '{4'hC, 8'hAA, 8'hAA},
		'{4'hC, 8'hFF, 8'hFF}, '{4'hD, 8'h00, 8'hE0}, '{4'hD, 8'h1F, 8'hFF},
		'{4'hE, 8'h5A, 8'h00}, '{4'hC, 8'h03, 8'h03}};

	// 40 MHz system clock
	always #12.5 clk = ~clk;

	free_timer DUT (.i_clk(clk), .i_rst(rst), .i_low_power(lp), .i_bus(bus), .o_bus_rdata(rdata),
		.i_capture_pin(cap), .i_ext_clk(ext), .o_compare_pin(pin), .o_compare_pin_oe(pin_oe),
		.o_capture_event(), .o_compare_match(), .o_overflow());
	cpu_host host (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

	task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// One slow external count edge, well above the minimum pulse width
	task automatic tick;
		@(negedge clk);
		ext = 1'b1;
		repeat (4) @(negedge clk);
		ext = 1'b0;
		repeat (4) @(negedge clk);
	endtask : tick

	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end

	// Main sequence: reset values, register rows, then the awkward cases
	initial
	begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		host.rd8(4'hC, d8);
		check("capture ctrl", 16'h0000, {8'h00, d8});
		host.rd8(4'hD, d8);
		check("compare ctrl", 16'h00E0, {8'h00, d8});
		check("pins", 16'h0000, {12'h000, pin_oe, pin});
		foreach (rows[i])
		begin
			host.wr8(rows[i].addr, rows[i].wdata);
			host.rd8(rows[i].addr, d8);
			check("control byte", {8'h00, rows[i].exp}, {8'h00, d8});
		end
		@(negedge clk);
		lp = 1'b1;
		@(negedge clk);
		lp = 1'b0;
		host.rd8(4'hC, d8);
		check("capture ctrl", 16'h0000, {8'h00, d8});
		host.rd8(4'hD, d8);
		check("compare ctrl", 16'h00E0, {8'h00, d8});
		host.wr8(4'hC, 8'h03);
		host.wr16(4'h0, 16'hAA55);
		host.rd16(4'h0, got);
		check("counter", 16'hAA55, got);
		// Interleaved upper write to another word replaces the held byte
		host.wr8(4'h0, 8'h12);
		host.wr8(4'h2, 8'h34);
		host.wr8(4'h1, 8'h56);
		host.rd16(4'h0, got);
		check("counter", 16'h3456, got);
		host.wr8(4'hD, 8'h00);
		host.wr16(4'h2, 16'h0010);
		host.wr8(4'hD, 8'h10);
		host.wr16(4'h2, 16'h5678);
		host.wr8(4'hD, 8'h0F);
		host.rd16(4'h2, got);
		check("compare A", 16'h0010, got);
		host.wr8(4'hD, 8'h1F);
		host.rd16(4'h2, got);
		check("compare B", 16'h5678, got);
		host.wr16(4'h0, 16'h0010);
		check("pins", 16'h0000, {14'h0000, pin});
		tick();
		check("pins", 16'h0001, {14'h0000, pin});
		check("pin enables", 16'h0003, {14'h0000, pin_oe});
		host.rd8(4'h0, d8);
		host.rd8(4'h3, d8);
		check("compare B low", 16'h0078, {8'h00, d8});
		// Rising edge on A, buffered into C; a falling edge must not capture
		host.wr8(4'hC, 8'h8B);
		host.wr16(4'h0, 16'h1111);
		cap = 4'h1;
		repeat (4) @(negedge clk);
		host.wr16(4'h0, 16'h2222);
		cap = 4'h0;
		repeat (4) @(negedge clk);
		cap = 4'h1;
		repeat (4) @(negedge clk);
		host.rd16(4'h4, got);
		check("capture A", 16'h2222, got);
		host.rd16(4'h8, got);
		check("capture C", 16'h1111, got);
		report_and_stop();
	end
endmodule : free_timer_bench

bind free_timer timer_sva chk (.i_clk(i_clk), .i_rst(i_rst), .i_low_power(i_low_power), .i_bus(i_bus),
	.o_bus_rdata(o_bus_rdata), .i_capture_pin(i_capture_pin), .o_compare_pin(o_compare_pin),
	.o_compare_pin_oe(o_compare_pin_oe), .o_capture_event(o_capture_event), .o_compare_match(o_compare_match));
